// file: design/cdbc_regs.svh
// constants of the click duration batch counter: reset values, pin slots, timing counts
// assumes a 250 MHz core clock; included by the package and the top module
`ifndef CDBC_REGS_SVH
`define CDBC_REGS_SVH

// ==========================================================
// clock and timing
`define CDBC_CLK_KHZ 250000
`define CDBC_MS2CYC(ms) ((ms) * `CDBC_CLK_KHZ)
`define CDBC_BEEP_ACC_MS 50
`define CDBC_BEEP_REJ_MS 300
`define CDBC_BEEP_BATCH_MS 1000
`define CDBC_DONE_MS 500
`define CDBC_SCROLL_MS 250

// ==========================================================
// slots of the synchronised pin vector
`define CDBC_PIN_KEY 0
`define CDBC_PIN_DIR 1
`define CDBC_PIN_SUSP 2
`define CDBC_PIN_MODE 3
`define CDBC_PIN_SET 4
`define CDBC_PIN_UP 5
`define CDBC_PIN_DOWN 6
`define CDBC_PIN_W 7

// ==========================================================
// reset values of every parameter set, message length width and window size
`define CDBC_RST_MIN 16'h0064
`define CDBC_RST_MAX 16'h00C8
`define CDBC_RST_BATCH 16'h000A
`define CDBC_MSG_LEN_W 4
`define CDBC_WIN_CHARS 4

`endif

// file: design/cdbc_pkg.sv
// types of the click duration batch counter
// assumes cdbc_regs.svh on the include path
`include "cdbc_regs.svh"

package cdbc_pkg;
  // ==========================================================
  // modes
  typedef enum logic [2:0] {ST_RUN = 3'h1, ST_PSEL = 3'h2, ST_EDIT = 3'h4} cdbc_state_t;
  typedef enum logic [2:0] {FLD_MIN = 3'h1, FLD_MAX = 3'h2, FLD_BATCH = 3'h4} cdbc_field_t;
  typedef enum logic [1:0] {SHOW_COUNT = 2'h1, SHOW_REMAIN = 2'h2} cdbc_show_t;

  // ==========================================================
  // whole state of the top module
  typedef struct packed {
    logic [`CDBC_PIN_W-1:0] sync1;
    logic [`CDBC_PIN_W-1:0] sync2;
    logic [`CDBC_PIN_W-1:0] prev;
    cdbc_state_t state;
    cdbc_field_t field;
    cdbc_show_t show;
    logic [1:0] set_idx;
    logic [3:0][15:0] min_click_time;
    logic [3:0][15:0] max_click_time;
    logic [3:0][15:0] batch;
    logic [15:0] tally;
    logic susp;
    logic led_acc;
    logic led_rej;
    logic led_err;
    logic led_susp;
    logic led_run;
    logic buzzer;
    logic batch_done;
    logic [31:0] buzz_cnt;
    logic [31:0] done_cnt;
  } cdbc_top_st_t;

  // ==========================================================
  // whole state of the scroller
  typedef struct packed {
    logic [31:0] tick;
    logic [`CDBC_MSG_LEN_W-1:0] pos;
    logic [31:0] chars;
  } cdbc_scr_st_t;
endpackage

// file: design/cdbc_disp_if.sv
// message carrier between the counter core and the display scroller
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface cdbc_disp_if;
  logic [7:0][7:0] msg;
  logic [3:0] msg_len;
  logic restart;
  logic [31:0] chars;

  modport src
  (
    output msg,
    output msg_len,
    output restart,
    input chars
  );
  modport scr
  (
    input msg,
    input msg_len,
    input restart,
    output chars
  );
endinterface

// file: design/cdbc_scroller.sv
// four character display window that scrolls long messages right to left
// assumes msg[0] is the first character and msg_len lies in 1..8
`timescale 1ns/1ps

module cdbc_scroller
  import cdbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [31:0] step,
  cdbc_disp_if.scr dp
);
  cdbc_scr_st_t s;
  cdbc_scr_st_t next_s;

  // ==========================================================
  // character at window slot, blank past the end of the message
  function automatic logic [7:0] char_at(input logic [3:0] p);
    return (p < dp.msg_len) ? dp.msg[p[2:0]] : 8'h20;
  endfunction

  // ==========================================================
  // window position and step timer
  always_comb
  begin
    next_s = s;
    if (dp.restart || dp.msg_len <= 4'h4)
    begin
      next_s.pos = 4'h0;
      next_s.tick = 32'h0;
    end
    else if (s.tick + 32'h1 >= step)
    begin
      next_s.tick = 32'h0;
      // wrap only after the tail has left the window, so the text walks off left
      next_s.pos = (s.pos >= dp.msg_len) ? 4'h0 : s.pos + 4'h1;
    end
    else
    begin
      next_s.tick = s.tick + 32'h1;
    end
    for (int i = 0; i < `CDBC_WIN_CHARS; i++)
    begin
      next_s.chars[31 - 8 * i -: 8] = char_at(next_s.pos + 4'(i));
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign dp.chars = s.chars;

  // ==========================================================
  // checks
  AST_SHORT_STILL: assert property (@(posedge clk) disable iff (!rst_n)
    ce && dp.msg_len <= 4'h4 |=> s.pos == 4'h0)
    else $error("short message moved");
endmodule

// file: design/cdbc_top.sv
// click duration batch counter: judges each wrench cycle in run mode and counts a batch
// assumes durations arrive as one-cycle strobes from radio logic on clk;
// keys, buttons and direction come from pins and are synchronised here
`timescale 1ns/1ps
`include "cdbc_regs.svh"

module cdbc_top
  import cdbc_pkg::*;
#(
  parameter logic [31:0] BEEP_ACC = `CDBC_MS2CYC(`CDBC_BEEP_ACC_MS),
  parameter logic [31:0] BEEP_REJ = `CDBC_MS2CYC(`CDBC_BEEP_REJ_MS),
  parameter logic [31:0] BEEP_BATCH = `CDBC_MS2CYC(`CDBC_BEEP_BATCH_MS),
  parameter logic [31:0] DONE_HOLD = `CDBC_MS2CYC(`CDBC_DONE_MS),
  parameter logic [31:0] SCROLL_STEP = `CDBC_MS2CYC(`CDBC_SCROLL_MS)
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic dur_valid,
  input wire logic [15:0] dur_value,
  input wire logic key_program_key_position,
  input wire logic count_down,
  input wire logic btn_suspend,
  input wire logic btn_mode,
  input wire logic btn_set,
  input wire logic btn_up,
  input wire logic btn_down,
  output logic led_accept,
  output logic led_reject,
  output logic led_error,
  output logic led_suspend,
  output logic led_run,
  output logic buzzer,
  output logic batch_done,
  output logic [31:0] disp_chars
);
  cdbc_top_st_t s;
  cdbc_top_st_t next_s;
  cdbc_disp_if dif();

  logic [`CDBC_PIN_W-1:0] pins;
  logic [`CDBC_PIN_W-1:0] press;
  logic key;
  logic dir_dn;
  logic dir_chg;
  logic in_rng;
  logic judge;
  logic good;
  logic last;
  logic [15:0] cur_batch;
  logic [15:0] shown;

  // ==========================================================
  // hex digit to display character, used for every numeric field
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // ==========================================================
  // pin view: buttons are taken on their rising edge after two flops;
  // no debounce here, bounce filtering is left to the front panel
  assign pins = {btn_down, btn_up, btn_set, btn_mode, btn_suspend, count_down, key_program_key_position};
  assign press = s.sync2 & ~s.prev;
  assign key = s.sync2[`CDBC_PIN_KEY];
  assign dir_dn = s.sync2[`CDBC_PIN_DIR];
  assign dir_chg = s.sync2[`CDBC_PIN_DIR] ^ s.prev[`CDBC_PIN_DIR];
  assign cur_batch = s.batch[s.set_idx];

  // inclusive window on the active set
  assign in_rng = dur_value >= s.min_click_time[s.set_idx] &&
    dur_value <= s.max_click_time[s.set_idx];
  assign judge = dur_valid && s.state == ST_RUN && key == 1'b0;
  assign good = judge && in_rng && !s.susp && !dir_chg;
  assign last = dir_dn ? (s.tally <= 16'h1) : (s.tally + 16'h1 >= cur_batch);

  // ==========================================================
  // next state of the whole core
  always_comb
  begin
    next_s = s;
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.buzz_cnt = (s.buzz_cnt != 32'h0) ? s.buzz_cnt - 32'h1 : 32'h0;
    next_s.done_cnt = (s.done_cnt != 32'h0) ? s.done_cnt - 32'h1 : 32'h0;

    // a changed count direction restarts the batch from its own origin
    if (dir_chg)
      next_s.tally = dir_dn ? cur_batch : 16'h0;

    // key position picks the mode; leaving program restarts the batch
    if (!key && s.state != ST_RUN)
    begin
      next_s.state = ST_RUN;
      next_s.tally = dir_dn ? cur_batch : 16'h0;
    end
    else
    begin
      case (s.state)
        ST_RUN:
        begin
          if (key)
            next_s.state = ST_PSEL;
          if (!key && press[`CDBC_PIN_SUSP])
            next_s.susp = !s.susp;
          if (!key && press[`CDBC_PIN_MODE])
            next_s.show = (s.show == SHOW_COUNT) ? SHOW_REMAIN : SHOW_COUNT;
          if (judge)
          begin
            next_s.led_acc = in_rng;
            next_s.led_rej = !in_rng;
            next_s.led_err = !in_rng;
            next_s.buzz_cnt = in_rng ? BEEP_ACC : BEEP_REJ;
          end
          if (good)
          begin
            if (last)
            begin
              next_s.tally = dir_dn ? cur_batch : 16'h0;
              next_s.done_cnt = DONE_HOLD;
              next_s.buzz_cnt = BEEP_BATCH;
            end
            else
            begin
              next_s.tally = dir_dn ? s.tally - 16'h1 : s.tally + 16'h1;
            end
          end
        end
        ST_PSEL:
        begin
          if (press[`CDBC_PIN_UP])
            next_s.set_idx = s.set_idx + 2'h1;
          else if (press[`CDBC_PIN_DOWN])
            next_s.set_idx = s.set_idx - 2'h1;
          if (press[`CDBC_PIN_SET])
          begin
            next_s.state = ST_EDIT;
            next_s.field = FLD_MIN;
          end
        end
        ST_EDIT:
        begin
          // only the active set is touched while editing
          case (s.field)
            FLD_MIN:
            begin
              if (press[`CDBC_PIN_UP])
                next_s.min_click_time[s.set_idx] = s.min_click_time[s.set_idx] + 16'h1;
              else if (press[`CDBC_PIN_DOWN])
                next_s.min_click_time[s.set_idx] = s.min_click_time[s.set_idx] - 16'h1;
              if (press[`CDBC_PIN_SET])
                next_s.field = FLD_MAX;
            end
            FLD_MAX:
            begin
              if (press[`CDBC_PIN_UP])
                next_s.max_click_time[s.set_idx] = s.max_click_time[s.set_idx] + 16'h1;
              else if (press[`CDBC_PIN_DOWN])
                next_s.max_click_time[s.set_idx] = s.max_click_time[s.set_idx] - 16'h1;
              if (press[`CDBC_PIN_SET])
                next_s.field = FLD_BATCH;
            end
            FLD_BATCH:
            begin
              // a batch of zero would complete on every accepted cycle, so the down button stops at one
              if (press[`CDBC_PIN_UP])
                next_s.batch[s.set_idx] = cur_batch + 16'h1;
              else if (press[`CDBC_PIN_DOWN] && cur_batch > 16'h1)
                next_s.batch[s.set_idx] = cur_batch - 16'h1;
              if (press[`CDBC_PIN_SET])
                next_s.state = ST_PSEL;
            end
            default: next_s.field = FLD_MIN;
          endcase
        end
        default: next_s.state = ST_RUN;
      endcase
    end

    next_s.led_susp = next_s.susp;
    next_s.led_run = next_s.state == ST_RUN;
    next_s.buzzer = next_s.buzz_cnt != 32'h0;
    next_s.batch_done = next_s.done_cnt != 32'h0;
  end

  // ==========================================================
  // state register; ce low freezes everything, synchronisers included
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.state <= ST_RUN;
      s.field <= FLD_MIN;
      s.show <= SHOW_COUNT;
      s.min_click_time <= {4{`CDBC_RST_MIN}};
      s.max_click_time <= {4{`CDBC_RST_MAX}};
      s.batch <= {4{`CDBC_RST_BATCH}};
      s.led_run <= 1'b1;
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // display message: count or remaining in run, set letter or value in program
  always_comb
  begin
    shown = 16'h0;
    dif.msg = {8{8'h20}};
    dif.msg_len = 4'h4;
    case (s.state)
      ST_RUN:
      begin
        // the tally is the count going up and the remainder going down
        if ((s.show == SHOW_COUNT) ^ dir_dn)
          shown = s.tally;
        else
          shown = cur_batch - s.tally;
        for (int i = 0; i < 4; i++)
          dif.msg[i] = hex_ch(shown[15 - 4 * i -: 4]);
      end
      ST_PSEL:
      begin
        dif.msg[0] = 8'h53;
        dif.msg[1] = 8'h45;
        dif.msg[2] = 8'h54;
        dif.msg[4] = 8'h41 + {6'h0, s.set_idx};
        dif.msg_len = 4'h5;
      end
      ST_EDIT:
      begin
        case (s.field)
          FLD_MIN: shown = s.min_click_time[s.set_idx];
          FLD_MAX: shown = s.max_click_time[s.set_idx];
          default: shown = cur_batch;
        endcase
        dif.msg[0] = (s.field == FLD_MIN) ? 8'h4C : (s.field == FLD_MAX) ? 8'h48 : 8'h42;
        dif.msg[1] = 8'h3D;
        for (int i = 0; i < 4; i++)
          dif.msg[i + 2] = hex_ch(shown[15 - 4 * i -: 4]);
        dif.msg_len = 4'h6;
      end
      default: dif.msg_len = 4'h4;
    endcase
  end

  // restart the scroll whenever the subject of the display changes
  assign dif.restart = (|press) || dir_chg;

  cdbc_scroller u_scr
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .step(SCROLL_STEP),
    .dp(dif.scr)
  );

  // ==========================================================
  // outputs, each straight from a flop
  assign led_accept = s.led_acc;
  assign led_reject = s.led_rej;
  assign led_error = s.led_err;
  assign led_suspend = s.led_susp;
  assign led_run = s.led_run;
  assign buzzer = s.buzzer;
  assign batch_done = s.batch_done;
  assign disp_chars = dif.chars;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_up;
    ce && good && !dir_dn && s.tally + 16'h1 >= cur_batch;
  endsequence
  sequence s_last_dn;
    ce && good && dir_dn && s.tally <= 16'h1;
  endsequence

  AST_JUDGE_EDGE: assert property (
    ce && judge && dur_value == s.max_click_time[s.set_idx] &&
    dur_value >= s.min_click_time[s.set_idx] |=> led_accept && !led_reject)
    else $error("duration on the upper limit was not accepted");
  AST_ACCEPT: assert property (
    ce && judge && in_rng |=> led_accept && !led_reject)
    else $error("accept lamp missing");
  AST_REJECT: assert property (
    ce && judge && dur_value < s.min_click_time[s.set_idx] |=> led_reject && !led_accept)
    else $error("short click not rejected");
  AST_ERROR: assert property (
    ce && judge && !in_rng |=> led_error)
    else $error("error lamp missing");
  AST_BUZZ: assert property (
    ce && judge |=> buzzer)
    else $error("no beep after a cycle");
  AST_COUNT: assert property (
    ce && good && !last && !dir_dn |=> s.tally == $past(s.tally) + 16'h1)
    else $error("accepted cycle not counted");
  AST_NO_COUNT: assert property (
    ce && judge && !in_rng && !dir_chg |=> $stable(s.tally))
    else $error("rejected cycle changed the count");
  AST_DONE: assert property (
    s_last_up |=> batch_done && buzzer ##1 batch_done)
    else $error("batch completion not signalled");
  AST_RELOAD_UP: assert property (
    s_last_up |=> s.tally == 16'h0)
    else $error("count up batch not reloaded to zero");
  AST_RELOAD_DN: assert property (
    s_last_dn |=> s.tally == $past(cur_batch))
    else $error("count down batch not reloaded to size");
  AST_SUSP: assert property (
    ce && judge && s.susp && !dir_chg |=> $stable(s.tally))
    else $error("suspended cycle was counted");
  AST_SUSP_LED: assert property (
    ce && s.state == ST_RUN && !key && press[`CDBC_PIN_SUSP] |=>
    led_suspend != $past(led_suspend))
    else $error("suspend lamp did not follow the button");
  AST_LOCK: assert property (
    ce && !key |=> s.state == ST_RUN && led_run)
    else $error("locked key did not give normal mode");
  AST_RUN_LED: assert property (
    led_run == (s.state == ST_RUN))
    else $error("run lamp disagrees with mode");
  AST_MODE: assert property (
    ce && s.state == ST_RUN && !key && press[`CDBC_PIN_MODE] |=> s.show != $past(s.show))
    else $error("mode button did not step the display");
  AST_SET_UP: assert property (
    ce && key && s.state == ST_PSEL && press[`CDBC_PIN_UP] |=>
    s.set_idx == $past(s.set_idx) + 2'h1)
    else $error("up did not move to the next set");
  AST_EDIT_ONE: assert property (
    ce && key && s.state == ST_EDIT && s.field == FLD_MIN && press[`CDBC_PIN_UP] |=>
    s.min_click_time[s.set_idx] == $past(s.min_click_time[s.set_idx]) + 16'h1 &&
    $stable(s.max_click_time))
    else $error("edit did not change the active minimum alone");
endmodule

// file: tb/cdbc_wrench_model.sv
// behavioural wrench: times the clicked position and reports the duration
// assumes the bench pulses go for one cycle; durations count clk cycles
`timescale 1ns/1ps

module cdbc_wrench_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [15:0] hold,
  output logic dur_valid,
  output logic [15:0] dur_value,
  output logic busy
);
  logic clicked;
  logic [15:0] timer;

  // ==========================================================
  // click timer and report
  // outside the strobe the data lines toggle, so a stale value is never mistaken for data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clicked <= 1'b0;
      timer <= 16'h0000;
      dur_valid <= 1'b0;
      dur_value <= 16'hFFFF;
    end
    else
    begin
      dur_valid <= 1'b0;
      dur_value <= ~dur_value;
      if (go && !clicked)
      begin
        clicked <= 1'b1;
        timer <= 16'h0001;
      end
      else if (clicked && timer == hold)
      begin
        clicked <= 1'b0;
        dur_valid <= 1'b1;
        dur_value <= timer;
      end
      else if (clicked)
      begin
        timer <= timer + 16'h0001;
      end
    end
  end

  assign busy = clicked | dur_valid;
endmodule

// file: tb/cdbc_top_tb.sv
// self-checking bench of the click duration batch counter
// assumes short beep and hold parameters; ce drops once to show that it freezes the core
`timescale 1ns/1ps

module cdbc_top_tb;
  logic clk;
  logic rst_n;
  logic ce;
  logic key_program_key_position;
  logic count_down;
  logic [4:0] btn;
  logic go;
  logic [15:0] hold;
  logic dur_valid;
  logic [15:0] dur_value;
  logic busy;
  logic led_accept;
  logic led_reject;
  logic led_error;
  logic led_suspend;
  logic led_run;
  logic buzzer;
  logic batch_done;
  logic [31:0] disp_chars;
  int err_total;
  int total_checks;
  int i;

  // ==========================================================
  // clock, design and wrench
  always #2 clk = ~clk;

  cdbc_top #(.BEEP_ACC(32'h3), .BEEP_REJ(32'h5), .BEEP_BATCH(32'h8), .DONE_HOLD(32'h4),
    .SCROLL_STEP(32'h4)) u_dut
  (
    .clk(clk), .rst_n(rst_n), .ce(ce), .dur_valid(dur_valid), .dur_value(dur_value),
    .key_program_key_position(key_program_key_position), .count_down(count_down), .btn_suspend(btn[0]), .btn_mode(btn[1]),
    .btn_set(btn[2]), .btn_up(btn[3]), .btn_down(btn[4]), .led_accept(led_accept),
    .led_reject(led_reject), .led_error(led_error), .led_suspend(led_suspend),
    .led_run(led_run), .buzzer(buzzer), .batch_done(batch_done), .disp_chars(disp_chars)
  );

  cdbc_wrench_model u_wrench
  (
    .clk(clk), .rst_n(rst_n), .go(go), .hold(hold), .dur_valid(dur_valid),
    .dur_value(dur_value), .busy(busy)
  );

  // ==========================================================
  // shared tasks
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one wrench cycle; the outcome is looked at right after the judging edge
  task automatic click(input logic [15:0] d, input logic acc, input logic done);
    go <= 1'b1;
    hold <= d;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk iff dur_valid);
    #1;
    chk(led_accept, acc);
    chk(led_reject, !acc);
    chk(led_error, !acc);
    chk(buzzer, 1'b1);
    chk(batch_done, done);
    repeat (12) @(posedge clk);
    #1;
    chk(buzzer, 1'b0);
  endtask

  // buttons have no debounce inside, so hold and release for clear margins
  task automatic press(input int b);
    @(posedge clk);
    btn[b] <= 1'b1;
    repeat (6) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic wait_disp(input logic [31:0] v);
    int n;
    // poll off the edge, so the value tested is the one that is then compared
    for (n = 0; n < 40 && disp_chars !== v; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk(disp_chars, v);
  endtask

  // ==========================================================
  // watchdog: the tests need well under 50000 cycles
  initial
  begin
    #200000;
    err_total++;
    end_sim();
  end

  // ==========================================================
  // test sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    key_program_key_position = 1'b0;
    count_down = 1'b0;
    btn = 5'h00;
    go = 1'b0;
    hold = 16'h0000;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(led_run, 1'b1);
    chk(led_suspend, 1'b0);
    chk(disp_chars, 32'h30303030);
    // limits are inclusive: just outside rejects, on the limit accepts
    click(16'h0063, 1'b0, 1'b0);
    click(16'h0064, 1'b1, 1'b0);
    click(16'h00C8, 1'b1, 1'b0);
    click(16'h00C9, 1'b0, 1'b0);
    wait_disp(32'h30303032);
    press(1);
    wait_disp(32'h30303038);
    press(1);
    wait_disp(32'h30303032);
    press(0);
    chk(led_suspend, 1'b1);
    click(16'h0096, 1'b1, 1'b0);
    wait_disp(32'h30303032);
    press(0);
    chk(led_suspend, 1'b0);
    // ce low freezes the synchronisers, so a mode press in that span is lost
    @(posedge clk);
    ce <= 1'b0;
    press(1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk(disp_chars, 32'h30303032);
    // program mode: set select scrolls and up/down step the set
    @(posedge clk);
    key_program_key_position <= 1'b1;
    wait_disp(32'h53455420);
    chk(led_run, 1'b0);
    wait_disp(32'h45542041);
    press(3);
    wait_disp(32'h45542042);
    // edit the minimum of set B by one, then step back out to set select
    press(2);
    wait_disp(32'h4C3D3030);
    press(3);
    wait_disp(32'h30303635);
    for (i = 0; i < 3; i++)
      press(2);
    wait_disp(32'h45542042);
    press(4);
    wait_disp(32'h45542041);
    @(posedge clk);
    key_program_key_position <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(led_run, 1'b1);
    // full batch counting up, then counting down; set A kept its own minimum
    for (i = 0; i < 10; i++)
      click((i == 0) ? 16'h0064 : 16'h0078, 1'b1, i == 9);
    wait_disp(32'h30303030);
    @(posedge clk);
    count_down <= 1'b1;
    repeat (8) @(posedge clk);
    for (i = 0; i < 10; i++)
      click(16'h0078, 1'b1, i == 9);
    wait_disp(32'h30303030);
    end_sim();
  end
endmodule
